//--- luma_noise_reduction.v
`timescale 1ns/10ps
`default_nettype none
`include "luma_nr_defines.vh"

module luma_noise_reduction (
    input  wire        i_core_clk,     // 40 MHz core clock
    input  wire        i_rst_b,        // sync reset, active low
    input  wire [11:0] i_axi_awaddr,   // write address
    input  wire        i_axi_awvalid,  // write address valid
    output reg         o_axi_awready,  // write address taken
    input  wire [31:0] i_axi_wdata,    // write data
    input  wire [3:0]  i_axi_wstrb,    // write byte enables
    input  wire        i_axi_wvalid,   // write data valid
    output reg         o_axi_wready,   // write data taken
    output reg  [1:0]  o_axi_bresp,    // write response
    output reg         o_axi_bvalid,   // write response valid
    input  wire        i_axi_bready,   // response accepted
    input  wire [11:0] i_axi_araddr,   // read address
    input  wire        i_axi_arvalid,  // read address valid
    output reg         o_axi_arready,  // read address taken
    output reg  [31:0] o_axi_rdata,    // read data
    output reg  [1:0]  o_axi_rresp,    // read response
    output reg         o_axi_rvalid,   // read data valid
    input  wire        i_axi_rready,   // read data accepted
    input  wire        i_pix_valid,    // video sample offered
    input  wire [7:0]  i_pix_data,     // video sample
    input  wire        i_pix_is_luma,  // sample is luma
    input  wire        i_pix_line,     // first luma of active line
    input  wire        i_pix_frame,    // first luma of frame
    output wire        o_pix_ready,    // sample taken
    output wire        o_out_valid,    // processed sample valid
    output wire [7:0]  o_out_data,     // processed sample
    output wire        o_out_is_luma,  // processed sample is luma
    input  wire        i_out_ready     // receiver takes sample
);

    ////////////////////////////////////////////////////////////////////////////
    // register file over axi4-lite

    reg  [7:0]  coring_gains_reg;
    reg  [7:0]  threshold_and_block_geometry_reg;
    reg  [7:0]  filter_mode_and_offset_reg;
    reg  [11:0] aw_addr_reg;
    reg         aw_held_reg;
    reg  [31:0] w_data_reg;
    reg  [3:0]  w_strb_reg;
    reg         w_held_reg;
    reg  [7:0]  status_reg;
    reg  [31:0] rd_word;
    reg         rd_hit;
    wire        aw_take;
    wire        w_take;
    wire        wr_go;

    assign aw_take = i_axi_awvalid & o_axi_awready;
    assign w_take  = i_axi_wvalid & o_axi_wready;
    assign wr_go   = aw_held_reg & w_held_reg & ~o_axi_bvalid;

    // address and data taken in either order, response after both
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_axi_awready <= 1'b0;
            o_axi_wready  <= 1'b0;
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= 12'h000;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            o_axi_bvalid  <= 1'b0;
            o_axi_bresp   <= `RESP_OKAY;
            coring_gains_reg                 <= `RST_CORING_GAINS;
            threshold_and_block_geometry_reg <= `RST_THRESHOLD_GEOMETRY;
            filter_mode_and_offset_reg       <= `RST_FILTER_MODE_SHIFT;
        end
        else
        begin
            o_axi_awready <= ~aw_held_reg & ~aw_take & ~o_axi_bvalid;
            o_axi_wready  <= ~w_held_reg & ~w_take & ~o_axi_bvalid;
            if (aw_take)
            begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= i_axi_awaddr;
            end
            if (w_take)
            begin
                w_held_reg <= 1'b1;
                w_data_reg <= i_axi_wdata;
                w_strb_reg <= i_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                o_axi_bvalid <= 1'b1;
                o_axi_bresp  <= `RESP_OKAY;
                // only byte lane 0 carries register bits
                case ({aw_addr_reg[11:2], 2'b00})
                    `ADDR_CORING_GAINS:
                        if (w_strb_reg[0])
                            coring_gains_reg <= w_data_reg[7:0];
                    `ADDR_THRESHOLD_GEOMETRY:
                        if (w_strb_reg[0])
                            threshold_and_block_geometry_reg <= w_data_reg[7:0];
                    `ADDR_FILTER_MODE_SHIFT:
                        if (w_strb_reg[0])
                            filter_mode_and_offset_reg <= w_data_reg[7:0];
                    default:
                        o_axi_bresp <= `RESP_SLVERR;
                endcase
            end
            else if (o_axi_bvalid && i_axi_bready)
                o_axi_bvalid <= 1'b0;
        end
    end

    // read decode; bits above the byte read as zero
    always @*
    begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case ({i_axi_araddr[11:2], 2'b00})
            `ADDR_CORING_GAINS:       rd_word[7:0] = coring_gains_reg;
            `ADDR_THRESHOLD_GEOMETRY: rd_word[7:0] = threshold_and_block_geometry_reg;
            `ADDR_FILTER_MODE_SHIFT:  rd_word[7:0] = filter_mode_and_offset_reg;
            `ADDR_NR_STATUS:          rd_word[7:0] = status_reg;
            default:                  rd_hit = 1'b0;
        endcase
    end

    // read channel: one read at a time
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_axi_arready <= 1'b0;
            o_axi_rvalid  <= 1'b0;
            o_axi_rdata   <= 32'h0000_0000;
            o_axi_rresp   <= `RESP_OKAY;
        end
        else if (i_axi_arvalid && o_axi_arready)
        begin
            o_axi_arready <= 1'b0;
            o_axi_rvalid  <= 1'b1;
            o_axi_rdata   <= rd_word;
            o_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        else if (o_axi_rvalid)
        begin
            if (i_axi_rready)
                o_axi_rvalid <= 1'b0;
        end
        else
            o_axi_arready <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // block grid position

    wire       pix_take;
    wire       luma_take;
    wire       blk16;
    wire       wide;
    wire [3:0] shift;
    wire [3:0] blk_mask;
    wire [3:0] edge_w;
    reg  [3:0] col_reg;
    reg  [3:0] row_reg;
    wire [3:0] cur_col;
    wire [3:0] cur_row;
    wire [3:0] col_pos;
    wire [3:0] row_pos;
    wire       col_border;
    wire       row_border;
    wire       border;

    assign pix_take  = i_pix_valid & o_pix_ready;
    assign luma_take = pix_take & i_pix_is_luma;
    assign blk16     = threshold_and_block_geometry_reg[`B_BLOCK_16];
    assign wide      = threshold_and_block_geometry_reg[`B_BORDER_WIDE];
    assign shift     = filter_mode_and_offset_reg[`F_GRID_SHIFT];
    assign blk_mask  = blk16 ? 4'hf : 4'h7;
    assign edge_w    = wide ? 4'h2 : 4'h1;

    // counts kept mod 16; 8-wide blocks just mask one bit off
    assign cur_col = i_pix_line ? 4'h0 : col_reg;
    assign cur_row = i_pix_frame ? 4'h0 : (i_pix_line ? row_reg + 4'h1 : row_reg);
    assign col_pos = (cur_col + shift) & blk_mask;
    assign row_pos = cur_row & blk_mask;

    // borders stay at fixed grid places; the shift slides the data
    assign col_border = (col_pos < edge_w) || (col_pos > (blk_mask - edge_w));
    assign row_border = (row_pos < edge_w) || (row_pos > (blk_mask - edge_w));
    assign border     = col_border | row_border;

    // pixel and line counters advance on luma only
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            col_reg <= 4'h0;
            row_reg <= 4'h0;
        end
        else if (luma_take)
        begin
            col_reg <= cur_col + 4'h1;
            row_reg <= cur_row;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // band filter, coring and clamp

    reg  [7:0]         x1_reg;
    reg  [7:0]         x2_reg;
    reg  [7:0]         x3_reg;
    wire signed [10:0] x0;
    wire signed [10:0] x1;
    wire signed [10:0] x2;
    wire signed [10:0] x3;
    reg  signed [10:0] band;
    wire [10:0]        mag;
    wire               below;
    wire               boost;
    wire [3:0]         gain_raw;
    wire [3:0]         gain;
    wire signed [15:0] prod;
    wire signed [15:0] amount;
    reg  signed [15:0] sum;
    reg  [7:0]         luma_out;
    wire [7:0]         out_byte;

    assign x0 = {3'b000, i_pix_data};
    assign x1 = i_pix_line ? x0 : {3'b000, x1_reg};
    assign x2 = i_pix_line ? x0 : {3'b000, x2_reg};                 // flat at line start
    assign x3 = i_pix_line ? x0 : {3'b000, x3_reg};

    // eight high-pass shapes over the last four luma samples
    always @*
    begin
        case (filter_mode_and_offset_reg[`F_BAND_SELECT])
            3'h0:    band = x0 - x1;
            3'h1:    band = (x0 - x2) >>> 1;
            3'h2:    band = ((x0 <<< 1) - x1 - x2) >>> 1;
            3'h3:    band = (x0 - (x1 <<< 1) + x2) >>> 2;
            3'h4:    band = (x0 - x3) >>> 1;
            3'h5:    band = ((x0 <<< 1) + x0 - x1 - x2 - x3) >>> 2;
            3'h6:    band = (x0 - x1 - x2 + x3) >>> 1;
            default: band = (x0 - x1) >>> 1;
        endcase
    end

    assign mag   = band[10] ? 11'd0 - band : band;
    assign below = mag < {5'b00000, threshold_and_block_geometry_reg[`F_THRESHOLD]};
    assign boost = filter_mode_and_offset_reg[`B_DETAIL_BOOST];

    // codes past unity add nothing, so the span tops at 1 or 0.5
    assign gain_raw = border ? coring_gains_reg[`F_GAIN_BORDER]
                             : coring_gains_reg[`F_GAIN_INTERIOR];
    assign gain     = (gain_raw > `GAIN_UNITY) ? `GAIN_UNITY : gain_raw;
    assign prod     = band * $signed({1'b0, gain});
    assign amount   = boost ? (prod >>> `BOOST_GAIN_SHIFT)
                            : (prod >>> `NOISE_GAIN_SHIFT);

    // correction then saturate to the legal range
    always @*
    begin
        sum = {8'h00, i_pix_data};
        if (!boost && below)
            sum = {8'h00, i_pix_data} - amount;
        else if (boost && !below && (mag != {5'b00000,
                 threshold_and_block_geometry_reg[`F_THRESHOLD]}))
            sum = {8'h00, i_pix_data} + amount;
        if (sum < $signed({8'h00, `LUMA_MIN}))
            luma_out = `LUMA_MIN;
        else if (sum > $signed({8'h00, `LUMA_MAX}))
            luma_out = `LUMA_MAX;
        else
            luma_out = sum[7:0];
    end

    assign out_byte = i_pix_is_luma ? luma_out : i_pix_data;

    // luma history restarts each line so no edge leaks across
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            x1_reg     <= 8'h00;
            x2_reg     <= 8'h00;
            x3_reg     <= 8'h00;
            status_reg <= 8'h00;
        end
        else if (luma_take)
        begin
            x1_reg     <= i_pix_data;
            x2_reg     <= i_pix_line ? i_pix_data : x1_reg;
            x3_reg     <= i_pix_line ? i_pix_data : x2_reg;
            status_reg <= {1'b0, below, border, row_border, col_pos};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output buffer; its ready throttles the input

    pix_skid_buffer #(
        .W (9)
    ) u_out_buf (
        .i_core_clk  (i_core_clk),
        .i_rst_b     (i_rst_b),
        .i_in_valid  (i_pix_valid),
        .i_in_data   ({i_pix_is_luma, out_byte}),
        .o_in_ready  (o_pix_ready),
        .o_out_valid (o_out_valid),
        .o_out_data  ({o_out_is_luma, o_out_data}),
        .i_out_ready (i_out_ready)
    );

endmodule
`default_nettype wire

//--- luma_noise_reduction_checker.sv
`timescale 1ns/10ps
`default_nettype none
module luma_nr_checker (
    input wire logic        i_core_clk,    // clock
    input wire logic        i_rst_b,       // reset
    input wire logic        i_axi_awvalid, // aw valid
    input wire logic        o_axi_awready, // aw ready
    input wire logic        i_axi_wvalid,  // w valid
    input wire logic        o_axi_wready,  // w ready
    input wire logic        o_axi_bvalid,  // b valid
    input wire logic        i_axi_bready,  // b ready
    input wire logic        i_axi_arvalid, // ar valid
    input wire logic        o_axi_arready, // ar ready
    input wire logic [31:0] o_axi_rdata,   // r data
    input wire logic        o_axi_rvalid,  // r valid
    input wire logic        i_axi_rready,  // r ready
    input wire logic        i_pix_valid,   // in valid
    input wire logic [7:0]  i_pix_data,    // in sample
    input wire logic        i_pix_is_luma, // in luma
    input wire logic        i_pix_line,    // in line start
    input wire logic        o_pix_ready,   // in ready
    input wire logic        o_out_valid,   // out valid
    input wire logic [7:0]  o_out_data,    // out sample
    input wire logic        o_out_is_luma, // out luma
    input wire logic        i_out_ready    // out ready
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    a_chroma_pass: assert property (
        i_pix_valid && o_pix_ready && !i_pix_is_luma && !o_out_valid
        |=> o_out_valid && !o_out_is_luma && o_out_data == $past(i_pix_data))
        else $error("chroma sample altered");
    // history reload at line start leaves a zero band, so no change
    a_line_start: assert property (
        i_pix_valid && o_pix_ready && i_pix_is_luma && i_pix_line && !o_out_valid
        |=> o_out_valid && o_out_is_luma && o_out_data == $past(i_pix_data))
        else $error("line start luma altered");
    a_write_answer: assert property (
        i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready
        |=> !o_axi_bvalid ##1 o_axi_bvalid)
        else $error("write response late");
    a_resp_hold: assert property (o_axi_bvalid |=> o_axi_bvalid != $past(i_axi_bready))
        else $error("write response dropped");
    a_read_answer: assert property (
        i_axi_arvalid && o_axi_arready |=> o_axi_rvalid && !o_axi_arready)
        else $error("read answer late");
    a_read_hold: assert property (o_axi_rvalid |=> $past(i_axi_rready) ? !o_axi_rvalid
        : o_axi_rvalid && $stable(o_axi_rdata))
        else $error("read data not held");
    // a stalled receiver must see the same word until it takes it
    a_out_hold: assert property (o_out_valid && !i_out_ready
        |=> o_out_valid && $stable(o_out_data) && $stable(o_out_is_luma))
        else $error("output word changed under stall");
    a_full_stall: assert property (
        $fell(o_pix_ready) |-> $past(o_out_valid) && !$past(i_out_ready))
        else $error("input refused without stall");
endmodule
bind luma_noise_reduction luma_nr_checker u_chk (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_axi_awvalid(i_axi_awvalid),
    .o_axi_awready(o_axi_awready), .i_axi_wvalid(i_axi_wvalid),
    .o_axi_wready(o_axi_wready), .o_axi_bvalid(o_axi_bvalid), .i_axi_bready(i_axi_bready),
    .i_axi_arvalid(i_axi_arvalid), .o_axi_arready(o_axi_arready),
    .o_axi_rdata(o_axi_rdata), .o_axi_rvalid(o_axi_rvalid), .i_axi_rready(i_axi_rready),
    .i_pix_valid(i_pix_valid), .i_pix_data(i_pix_data), .i_pix_is_luma(i_pix_is_luma),
    .i_pix_line(i_pix_line), .o_pix_ready(o_pix_ready), .o_out_valid(o_out_valid),
    .o_out_data(o_out_data), .o_out_is_luma(o_out_is_luma), .i_out_ready(i_out_ready));
`default_nettype wire

//--- luma_nr_defines.vh
`ifndef LUMA_NR_DEFINES_VH
`define LUMA_NR_DEFINES_VH

// register indices as printed; byte address is four times the index
`define IDX_CORING_GAINS       10'h0a3
`define IDX_THRESHOLD_GEOMETRY 10'h0a4
`define IDX_FILTER_MODE_SHIFT  10'h0a5
`define IDX_NR_STATUS          10'h0a6
`define ADDR_CORING_GAINS       {`IDX_CORING_GAINS, 2'b00}
`define ADDR_THRESHOLD_GEOMETRY {`IDX_THRESHOLD_GEOMETRY, 2'b00}
`define ADDR_FILTER_MODE_SHIFT  {`IDX_FILTER_MODE_SHIFT, 2'b00}
`define ADDR_NR_STATUS          {`IDX_NR_STATUS, 2'b00}

// reset values
`define RST_CORING_GAINS       8'h00
`define RST_THRESHOLD_GEOMETRY 8'h00
`define RST_FILTER_MODE_SHIFT  8'h00

// field positions
`define F_GAIN_BORDER    3:0
`define F_GAIN_INTERIOR  7:4
`define F_THRESHOLD      5:0
`define B_BORDER_WIDE    6
`define B_BLOCK_16       7
`define F_BAND_SELECT    2:0
`define B_DETAIL_BOOST   4
`define F_GRID_SHIFT     7:4

// gain limits and legal luma range
`define GAIN_UNITY       4'h8
`define NOISE_GAIN_SHIFT 3
`define BOOST_GAIN_SHIFT 4
`define LUMA_MIN         8'h00
`define LUMA_MAX         8'hff

// axi responses
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

//--- pix_skid_buffer.v
`timescale 1ns/10ps
`default_nettype none

// two-entry buffer; both ready and valid leave from flip-flops
module pix_skid_buffer #(
    parameter W = 9
) (
    input  wire         i_core_clk,  // core clock
    input  wire         i_rst_b,     // sync reset, active low
    input  wire         i_in_valid,  // word offered
    input  wire [W-1:0] i_in_data,   // word payload
    output reg          o_in_ready,  // room for a word
    output reg          o_out_valid, // head word valid
    output reg  [W-1:0] o_out_data,  // head word
    input  wire         i_out_ready  // receiver takes head
);

    reg  [W-1:0] tail_reg;
    reg          tail_v_reg;
    reg          tail_v_next;
    reg          head_v_next;
    wire         push;
    wire         pop;

    assign push = i_in_valid & o_in_ready;
    assign pop  = o_out_valid & i_out_ready;

    // occupancy next state
    always @*
    begin
        head_v_next = o_out_valid;
        tail_v_next = tail_v_reg;
        if (pop)
        begin
            head_v_next = tail_v_reg | push;
            tail_v_next = tail_v_reg & push;
        end
        else if (push)
        begin
            head_v_next = 1'b1;
            tail_v_next = o_out_valid;
        end
    end

    // data movement; ready drops only when both entries hold words
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
        begin
            o_out_valid <= 1'b0;
            tail_v_reg  <= 1'b0;
            o_in_ready  <= 1'b0;
            o_out_data  <= {W{1'b0}};
            tail_reg    <= {W{1'b0}};
        end
        else
        begin
            o_out_valid <= head_v_next;
            tail_v_reg  <= tail_v_next;
            o_in_ready  <= ~tail_v_next;
            if (pop && tail_v_reg)
                o_out_data <= tail_reg;
            else if (push && (!o_out_valid || pop))
                o_out_data <= i_in_data;
            if (push && o_out_valid && !(pop && !tail_v_reg))
                tail_reg <= i_in_data;
        end
    end

endmodule
`default_nettype wire

//--- pix_source.sv
`timescale 1ns/10ps
`default_nettype none
// upstream sample source: holds each word until the block takes it
module pix_source (
    input  wire logic       i_core_clk, // clock
    input  wire logic       i_rst_b,    // reset
    input  wire logic       i_ready,    // block ready
    output var  logic       o_valid,    // word valid
    output var  logic [7:0] o_data,     // sample
    output var  logic       o_is_luma,  // luma flag
    output var  logic       o_line,     // line start
    output var  logic       o_frame     // frame start
);
    logic [10:0] word_q[$];
    task push(input logic [10:0] w);
        word_q.push_back(w);
    endtask
    initial {o_valid, o_data, o_is_luma, o_line, o_frame} = 12'h000;
    // idle data toggles so a stale word never passes for a fresh one
    always @(posedge i_core_clk)
    begin
        if (!i_rst_b)
            o_valid <= 1'b0;
        else if (!o_valid || i_ready)
        begin
            if (word_q.size() > 0)
            begin
                {o_line, o_frame, o_is_luma, o_data} <= word_q.pop_front();
                o_valid <= 1'b1;
            end
            else
            begin
                o_valid <= 1'b0;
                o_data  <= ~o_data;
            end
        end
    end
endmodule
`default_nettype wire

//--- test_luma_noise_reduction.sv
`timescale 1ns/10ps
`default_nettype none
`include "luma_nr_defines.vh"
module test_luma_noise_reduction;
    logic        i_core_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        i_axi_awvalid = 1'b0, i_axi_wvalid = 1'b0, i_axi_bready = 1'b0;
    logic        i_axi_arvalid = 1'b0, i_axi_rready = 1'b0, i_out_ready = 1'b1;
    logic [11:0] i_axi_awaddr = 12'h000, i_axi_araddr = 12'h000;
    logic [31:0] i_axi_wdata = 32'h0;
    logic [3:0]  i_axi_wstrb = 4'h0;
    wire         o_axi_awready, o_axi_wready, o_axi_bvalid, o_axi_arready, o_axi_rvalid;
    wire  [1:0]  o_axi_bresp, o_axi_rresp;
    wire  [31:0] o_axi_rdata;
    wire         i_pix_valid, i_pix_is_luma, i_pix_line, i_pix_frame, o_pix_ready;
    wire  [7:0]  i_pix_data, o_out_data;
    wire         o_out_valid, o_out_is_luma;
    int          fails = 0;
    int          cmp_count = 0;
    logic [8:0]  out_q[$];
    always #12.5 i_core_clk = ~i_core_clk;
    luma_noise_reduction u_dut (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_axi_awaddr(i_axi_awaddr),
        .i_axi_awvalid(i_axi_awvalid), .o_axi_awready(o_axi_awready),
        .i_axi_wdata(i_axi_wdata), .i_axi_wstrb(i_axi_wstrb), .i_axi_wvalid(i_axi_wvalid),
        .o_axi_wready(o_axi_wready), .o_axi_bresp(o_axi_bresp), .o_axi_bvalid(o_axi_bvalid),
        .i_axi_bready(i_axi_bready), .i_axi_araddr(i_axi_araddr),
        .i_axi_arvalid(i_axi_arvalid), .o_axi_arready(o_axi_arready),
        .o_axi_rdata(o_axi_rdata), .o_axi_rresp(o_axi_rresp), .o_axi_rvalid(o_axi_rvalid),
        .i_axi_rready(i_axi_rready), .i_pix_valid(i_pix_valid), .i_pix_data(i_pix_data),
        .i_pix_is_luma(i_pix_is_luma), .i_pix_line(i_pix_line), .i_pix_frame(i_pix_frame),
        .o_pix_ready(o_pix_ready), .o_out_valid(o_out_valid), .o_out_data(o_out_data),
        .o_out_is_luma(o_out_is_luma), .i_out_ready(i_out_ready));
    pix_source u_src (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_ready(o_pix_ready),
        .o_valid(i_pix_valid), .o_data(i_pix_data), .o_is_luma(i_pix_is_luma),
        .o_line(i_pix_line), .o_frame(i_pix_frame));
    // receiver side: collect every word taken
    always @(posedge i_core_clk)
        if (i_rst_b && o_out_valid && i_out_ready)
            out_q.push_back({o_out_is_luma, o_out_data});
    ////////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        if (fails == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task timeout(input int n);
        if (n >= 200)
        begin
            fails++;
            report_and_stop;
        end
    endtask
    task chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk_pix(input logic [8:0] e);
        int n;
        n = 0;
        while (out_q.size() == 0 && n < 200)
        begin
            @(negedge i_core_clk);
            n++;
        end
        timeout(n);
        chk_val("pixel", {23'h0, e}, {23'h0, out_q.pop_front()});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                   input logic [1:0] r);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_axi_awaddr  <= a;
        i_axi_wdata   <= {24'h0, d};
        i_axi_wstrb   <= s;
        i_axi_awvalid <= 1'b1;
        i_axi_wvalid  <= 1'b1;
        i_axi_bready  <= 1'b1;
        do
        begin
            @(posedge i_core_clk);
            n++;
            if (o_axi_awready === 1'b1)
                i_axi_awvalid <= 1'b0;
            if (o_axi_wready === 1'b1)
                i_axi_wvalid <= 1'b0;
        end while (o_axi_bvalid !== 1'b1 && n < 200);
        i_axi_bready <= 1'b0;
        timeout(n);
        chk_val("bresp", {30'h0, r}, {30'h0, o_axi_bresp});
    endtask
    task axi_read(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_axi_araddr  <= a;
        i_axi_arvalid <= 1'b1;
        i_axi_rready  <= 1'b1;
        do
        begin
            @(posedge i_core_clk);
            n++;
            if (o_axi_arready === 1'b1)
                i_axi_arvalid <= 1'b0;
        end while (o_axi_rvalid !== 1'b1 && n < 200);
        i_axi_rready <= 1'b0;
        timeout(n);
        chk_val("rdata", {24'h0, e}, o_axi_rdata);
        chk_val("rresp", {30'h0, r}, {30'h0, o_axi_rresp});
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        axi_write(a, d, 4'h1, `RESP_OKAY);
    endtask
    task send(input logic l, input logic f, input logic lu, input logic [7:0] d);
        u_src.push({l, f, lu, d});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        axi_read(`ADDR_CORING_GAINS, `RST_CORING_GAINS, `RESP_OKAY);
        axi_read(`ADDR_THRESHOLD_GEOMETRY, `RST_THRESHOLD_GEOMETRY, `RESP_OKAY);
        axi_read(`ADDR_FILTER_MODE_SHIFT, `RST_FILTER_MODE_SHIFT, `RESP_OKAY);
        axi_write(12'h000, 8'h5a, 4'h1, `RESP_SLVERR);
        axi_read(12'h000, 8'h00, `RESP_SLVERR);
        wr(`ADDR_CORING_GAINS, 8'ha5);
        axi_write(`ADDR_CORING_GAINS, 8'h3c, 4'h0, `RESP_OKAY);
        axi_read(`ADDR_CORING_GAINS, 8'ha5, `RESP_OKAY);
        wr(`ADDR_THRESHOLD_GEOMETRY, 8'hc9);
        axi_read(`ADDR_THRESHOLD_GEOMETRY, 8'hc9, `RESP_OKAY);
        wr(`ADDR_FILTER_MODE_SHIFT, 8'hf7);
        axi_read(`ADDR_FILTER_MODE_SHIFT, 8'hf7, `RESP_OKAY);
    endtask
    // line start a reloads history, so the band of b depends on b-a only
    task pair(input logic [7:0] a, input logic [7:0] b, input logic [7:0] e);
        send(1'b1, 1'b0, 1'b1, a);
        send(1'b0, 1'b0, 1'b1, b);
        chk_pix({1'b1, a});
        chk_pix({1'b1, e});
    endtask
    task t_filters;
        logic [7:0] exp_tab [8];
        exp_tab = '{8'd100, 8'd104, 8'd100, 8'd106, 8'd104, 8'd102, 8'd104, 8'd104};
        wr(`ADDR_CORING_GAINS, 8'h88);
        wr(`ADDR_THRESHOLD_GEOMETRY, 8'h3f);
        for (int s = 0; s < 8; s++)
        begin
            wr(`ADDR_FILTER_MODE_SHIFT, s[7:0]);
            pair(8'd100, 8'd108, exp_tab[s]);
        end
    endtask
    task lvl(input logic [7:0] m, input logic [7:0] t, input logic [7:0] b,
             input logic [7:0] e);
        wr(`ADDR_FILTER_MODE_SHIFT, m);
        wr(`ADDR_THRESHOLD_GEOMETRY, t);
        pair(8'd100, b, e);
    endtask
    task t_levels;
        lvl(8'h00, 8'h08, 8'd108, 8'd108);
        lvl(8'h00, 8'h09, 8'd108, 8'd100);
        lvl(8'h10, 8'h08, 8'd108, 8'd108);
        lvl(8'h10, 8'h07, 8'd108, 8'd112);
        lvl(8'h10, 8'h00, 8'd250, 8'd255);
    endtask
    // border gain full, interior gain zero: only border pixels change
    task geo(input logic [7:0] g, input logic [3:0] s);
        logic [7:0] y;
        int         m, w, p;
        m = g[7] ? 15 : 7;
        w = g[6] ? 2 : 1;
        wr(`ADDR_CORING_GAINS, 8'h08);
        wr(`ADDR_THRESHOLD_GEOMETRY, g);
        wr(`ADDR_FILTER_MODE_SHIFT, {s, 4'h0});
        send(1'b1, 1'b1, 1'b1, 8'd50);
        send(1'b1, 1'b0, 1'b1, 8'd50);
        for (int k = 0; k < 20; k++)
            send(k == 0, 1'b0, 1'b1, 8'd60 + 8'(4 * k));
        chk_pix({1'b1, 8'd50});
        chk_pix({1'b1, 8'd50});
        for (int k = 0; k < 20; k++)
        begin
            p = (k + s) & m;
            y = 8'd60 + 8'(4 * k);
            chk_pix({1'b1, (k > 0 && (p < w || p > m - w)) ? y - 8'd4 : y});
        end
    endtask
    // receiver stalls for 8 cycles, long enough to fill both buffer entries
    task t_stall;
        @(posedge i_core_clk);
        i_out_ready <= 1'b0;
        send(1'b0, 1'b0, 1'b0, 8'h10);
        send(1'b0, 1'b0, 1'b0, 8'h20);
        send(1'b0, 1'b0, 1'b0, 8'h30);
        repeat (8) @(posedge i_core_clk);
        chk_val("pix_ready", 32'h0, {31'h0, o_pix_ready});
        i_out_ready <= 1'b1;
        chk_pix({1'b0, 8'h10});
        chk_pix({1'b0, 8'h20});
        chk_pix({1'b0, 8'h30});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        t_regs;
        t_filters;
        t_levels;
        geo(8'h3f, 4'h0);
        axi_read(`ADDR_NR_STATUS, 8'h43, `RESP_OKAY);
        geo(8'h7f, 4'h2);
        geo(8'hbf, 4'he);
        geo(8'hff, 4'h6);
        t_stall;
        report_and_stop;
    end
endmodule
`default_nettype wire
